// ### mem_slave_pkg.sv
// shared constants for the two-wire memory slave front end
package mem_slave_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 32768;
	localparam int STRAP_W = 3;
	localparam int TYPE_W = 4;
	// arbitrary neutral device type code, override per part
	localparam logic [3:0] TYPE_CODE_DEF = 4'h6;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int STRAP_MSB = 3;
	localparam int STRAP_LSB = 1;
	localparam int DIR_BIT = 0;
	localparam logic DIR_READ = 1'b1;
	localparam logic [14:0] PTR_RESET = 15'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] TX_IDLE = 8'hFF;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_AHI = 3'b010,
		ST_ALO = 3'b011,
		ST_WR = 3'b100,
		ST_RD = 3'b101
	} phase_t;
endpackage

// ### bit_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		meta_q <= async_in;
	end

	always_ff @(posedge clk) begin
		sync_out <= meta_q;
	end
endmodule

// ### byte_array.sv
// byte-wide storage array with registered read and gated write
`timescale 1ns/100ps
module byte_array #(
	parameter int ADDR_W = mem_slave_pkg::ADDR_W,
	parameter int DATA_W = mem_slave_pkg::DATA_W,
	parameter int DEPTH = mem_slave_pkg::MEM_DEPTH
) (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] cells [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_data <= cells[rd_addr];
	end
endmodule

// ### mem_slave.sv
// two-wire serial slave front end of a 32K x 8 memory
`timescale 1ns/100ps
// Function
// - slave only: never starts transfers, never drives the clock
// - sample data on clock rise, change driven data after clock fall
// - data line is open drain: pull low or release
// - start is data falling while clock high; device detects it
// - stop is data rising while clock high; ends operation, standby
// - ready at once after stop; no write wait, no polling
// - bytes are 8 bits; receiver pulls data low on ninth clock
// - transmitter releases data line during ninth clock
// - stop before acknowledge abandons operation into standby
// - after not-acknowledge device releases bus; master stops or restarts
// - top four bits must equal fixed device type code
// - next three bits, strap 2 first, must equal strap pins
// - three straps allow eight devices; open strap reads low
// - write protect high refuses array writes; low allows them
// - reads always allowed regardless of write protect
// - open write protect reads low, writes enabled
// - array of 32768 eight-bit locations
// - address word lsb: 0 write, 1 read
// - mismatch: no acknowledge, standby until next start
// - two address bytes high first acknowledged, then data bytes
module mem_slave #(
	parameter logic [3:0] TYPE_CODE = mem_slave_pkg::TYPE_CODE_DEF
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic write_protect,
	input wire logic [2:0] bus_select_straps,
	output logic addressed,
	output logic write_refused
);
	// link domain: capture each data bit on the clock rise
	logic link_rst_s;
	logic rx_bit_q;

	bit_sync #(.WIDTH(1)) u_link_rst (
		.clk(scl),
		.async_in(srst),
		.sync_out(link_rst_s)
	);

	always_ff @(posedge scl) begin
		if (link_rst_s) begin
			rx_bit_q <= 1'b1;
		end else begin
			rx_bit_q <= sda_in;
		end
	end

	// reference domain synchronisers
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] strap_s;
	logic rx_bit_s;

	bit_sync #(.WIDTH(6)) u_pin_sync (
		.clk(ref_clk),
		.async_in({scl, sda_in, write_protect, bus_select_straps}),
		.sync_out({scl_s, sda_s, wp_s, strap_s})
	);

	// captured bit is stable for a whole clock period, read only after a seen rise
	bit_sync #(.WIDTH(1)) u_bit_sync (
		.clk(ref_clk),
		.async_in(rx_bit_q),
		.sync_out(rx_bit_s)
	);

	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	logic start_ev;
	logic stop_ev;
	logic fall_ev;
	logic rise_ev;

	assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign fall_ev = scl_prev_q & ~scl_s;
	assign rise_ev = scl_rise_q;

	// clock rise used one cycle late so the synchronised data bit has surely settled
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_rise_q <= 1'b0;
		end else begin
			scl_rise_q <= scl_s & ~scl_prev_q;
		end
	end

	// byte engine
	mem_slave_pkg::phase_t phase_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [14:0] ptr_q;
	logic drive_low_q;
	logic wr_en;
	logic [7:0] rd_data;
	logic dev_match;
	logic take_ack;

	function automatic logic addr_word_match(input logic [7:0] w, input logic [3:0] code, input logic [2:0] straps);
		addr_word_match = (w[mem_slave_pkg::TYPE_MSB:mem_slave_pkg::TYPE_LSB] == code) &&
			(w[mem_slave_pkg::STRAP_MSB:mem_slave_pkg::STRAP_LSB] == straps);
	endfunction

	assign dev_match = addr_word_match(shift_q, TYPE_CODE, strap_s);

	// receiving phases acknowledge; a mismatched address word does not
	always_comb begin
		unique case (phase_q)
			mem_slave_pkg::ST_DEV: take_ack = dev_match;
			mem_slave_pkg::ST_AHI, mem_slave_pkg::ST_ALO, mem_slave_pkg::ST_WR: take_ack = 1'b1;
			default: take_ack = 1'b0;
		endcase
	end

	logic ack_rise;
	assign ack_rise = rise_ev & (cnt_q == mem_slave_pkg::ACK_SLOT);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_q <= mem_slave_pkg::ST_IDLE;
		end else if (start_ev) begin
			phase_q <= mem_slave_pkg::ST_DEV;
		end else if (stop_ev) begin
			phase_q <= mem_slave_pkg::ST_IDLE;
		end else if (ack_rise) begin
			unique case (phase_q)
				mem_slave_pkg::ST_DEV: begin
					if (!dev_match) begin
						phase_q <= mem_slave_pkg::ST_IDLE;
					end else if (shift_q[mem_slave_pkg::DIR_BIT] == mem_slave_pkg::DIR_READ) begin
						phase_q <= mem_slave_pkg::ST_RD;
					end else begin
						phase_q <= mem_slave_pkg::ST_AHI;
					end
				end
				mem_slave_pkg::ST_AHI: phase_q <= mem_slave_pkg::ST_ALO;
				mem_slave_pkg::ST_ALO: phase_q <= mem_slave_pkg::ST_WR;
				mem_slave_pkg::ST_RD: begin
					if (rx_bit_s) begin
						phase_q <= mem_slave_pkg::ST_IDLE;
					end
				end
				default: phase_q <= phase_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || start_ev || stop_ev) begin
			cnt_q <= 4'h0;
		end else if (ack_rise) begin
			cnt_q <= 4'h0;
		end else if (rise_ev) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_q <= mem_slave_pkg::BYTE_RESET;
		end else if (rise_ev && cnt_q != mem_slave_pkg::ACK_SLOT) begin
			shift_q <= {shift_q[6:0], rx_bit_s};
		end
	end

	// memory pointer: high byte msb is ignored, rolls over at the top
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ptr_q <= mem_slave_pkg::PTR_RESET;
		end else if (ack_rise) begin
			unique case (phase_q)
				mem_slave_pkg::ST_AHI: ptr_q <= {shift_q[6:0], ptr_q[7:0]};
				mem_slave_pkg::ST_ALO: ptr_q <= {ptr_q[14:8], shift_q};
				mem_slave_pkg::ST_WR: ptr_q <= ptr_q + 15'h0001;
				mem_slave_pkg::ST_DEV: begin
					if (dev_match && shift_q[mem_slave_pkg::DIR_BIT] == mem_slave_pkg::DIR_READ) begin
						ptr_q <= ptr_q + 15'h0001;
					end
				end
				mem_slave_pkg::ST_RD: begin
					if (!rx_bit_s) begin
						ptr_q <= ptr_q + 15'h0001;
					end
				end
				default: ptr_q <= ptr_q;
			endcase
		end
	end

	// transmit byte: loaded at the ack clock, shifted on each data rise
	always_ff @(posedge ref_clk) begin
		if (srst || start_ev) begin
			tx_q <= mem_slave_pkg::TX_IDLE;
		end else if (ack_rise) begin
			tx_q <= rd_data;
		end else if (rise_ev && phase_q == mem_slave_pkg::ST_RD) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	assign wr_en = ack_rise && phase_q == mem_slave_pkg::ST_WR && !wp_s;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			write_refused <= 1'b0;
		end else begin
			write_refused <= ack_rise && phase_q == mem_slave_pkg::ST_WR && wp_s;
		end
	end

	// data line drive: set after the clock falls; a start or stop releases it at once
	always_ff @(posedge ref_clk) begin
		if (srst || start_ev || stop_ev) begin
			drive_low_q <= 1'b0;
		end else if (fall_ev) begin
			if (cnt_q == mem_slave_pkg::ACK_SLOT) begin
				drive_low_q <= take_ack;
			end else if (phase_q == mem_slave_pkg::ST_RD) begin
				drive_low_q <= ~tx_q[7];
			end else begin
				drive_low_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sda_oe_n <= 1'b1;
		end else begin
			sda_oe_n <= ~drive_low_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			addressed <= 1'b0;
		end else begin
			addressed <= phase_q != mem_slave_pkg::ST_IDLE && phase_q != mem_slave_pkg::ST_DEV;
		end
	end

	// open drain: only ever pulls low, never drives the clock
	assign sda_out = 1'b0;

	byte_array #(
		.ADDR_W(mem_slave_pkg::ADDR_W),
		.DATA_W(mem_slave_pkg::DATA_W),
		.DEPTH(mem_slave_pkg::MEM_DEPTH)
	) u_array (
		.ref_clk(ref_clk),
		.wr_en(wr_en),
		.wr_addr(ptr_q),
		.wr_data(shift_q),
		.rd_addr(ptr_q),
		.rd_data(rd_data)
	);
endmodule

// ### mem_slave_properties.sv
// port assertions for the two-wire memory slave front end
`timescale 1ns/100ps
module mem_slave_properties (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic write_protect,
	input wire logic [2:0] bus_select_straps,
	input wire logic addressed,
	input wire logic write_refused
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_stop; scl && $rose(sda_in); endsequence
	sequence s_pull; $fell(sda_oe_n); endsequence
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("data value not low");
	property p_rst; $fell(srst) |-> sda_oe_n && !addressed && !write_refused; endproperty
	a_rst: assert property (p_rst) else $error("not idle after reset");
	property p_edge; $changed(sda_oe_n) |-> !scl; endproperty
	a_edge: assert property (p_edge) else $error("drive changed with clock high");
	property p_stop; s_stop |-> ##[1:8] (!addressed && sda_oe_n); endproperty
	a_stop: assert property (p_stop) else $error("stop did not idle");
	property p_ack; s_pull |-> ##[0:40] addressed; endproperty
	a_ack: assert property (p_ack) else $error("pulled low unaddressed");
	property p_rel; $fell(addressed) |-> sda_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("line held on leaving");
	property p_wp; write_refused |-> write_protect && addressed; endproperty
	a_wp: assert property (p_wp) else $error("refusal without protect");
	property p_pulse; write_refused |=> !write_refused; endproperty
	a_pulse: assert property (p_pulse) else $error("refusal pulse too long");
endmodule

// ### i2c_master_model.sv
// behavioural two-wire bus master with open-drain wire resolution
`timescale 1ns/100ps
module i2c_master_model (
	input wire logic dut_oe_n,
	input wire logic dut_out,
	output logic scl,
	output logic sda,
	output logic rs,
	output logic rk,
	output logic [7:0] rv
);
	logic tick;
	logic pull;
	assign sda = ((dut_oe_n === 1'b0) ? dut_out : 1'b1) & ~pull;
	initial begin
		{scl, pull, rs, rk, rv} = {1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
		tick = 1'b0;
		#7.3;
		forever #62.5 tick = ~tick;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge tick);
	endtask
	// one bit at 1 MHz; data moves a tick after the fall
	task automatic bitx(input logic b, output logic s);
		hw(1);
		pull = ~b;
		hw(3);
		scl = 1'b1;
		hw(4);
		s = sda;
		scl = 1'b0;
	endtask
	// start when stp is low, stop when high
	task automatic cond(input logic stp);
		hw(1);
		pull = stp;
		hw(3);
		scl = 1'b1;
		hw(4);
		pull = ~stp;
		hw(4);
		scl = stp;
	endtask
	task automatic report(input logic k, input logic [7:0] v);
		{rk, rv, rs} = {k, v, 1'b1};
		hw(1);
		rs = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, input int n);
		logic s;
		for (int i = 7; i > 7 - n; i--) bitx(d[i], s);
		if (n == 8) begin
			bitx(1'b1, s);
			report(1'b0, {7'h00, ~s});
		end
	endtask
	task automatic rbyte(input logic ack);
		logic [7:0] d;
		logic s;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(~ack, s);
		report(1'b1, d);
	endtask
endmodule

// ### tb_top.sv
// testbench for the two-wire memory slave front end
`timescale 1ns/100ps
module tb_top;
	localparam logic [3:0] TC = mem_slave_pkg::TYPE_CODE_DEF;
	logic ref_clk;
	logic srst;
	logic write_protect;
	logic sda_out;
	logic sda_oe_n;
	logic addressed;
	logic write_refused;
	logic scl;
	logic sda;
	logic rs;
	logic rk;
	logic [2:0] straps;
	logic [7:0] rv;
	logic [7:0] d0;
	logic [7:0] d1;
	logic [8:0] e;
	logic [8:0] q[$];
	int seed = 28813;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_ref = 0;
	int cyc = 0;
	mem_slave #(.TYPE_CODE(TC)) dut (.ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .write_protect(write_protect), .bus_select_straps(straps), .addressed(addressed),
		.write_refused(write_refused));
	i2c_master_model m (.dut_oe_n(sda_oe_n), .dut_out(sda_out), .scl(scl), .sda(sda), .rs(rs), .rk(rk), .rv(rv));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk_bit(input string what, input logic x, input logic g);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", what, x, g);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] x, input logic [7:0] g);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, x, g);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic sw(input logic [7:0] d, input logic ea);
		q.push_back({1'b0, 7'h00, ea});
		m.wbyte(d, 8);
	endtask
	task automatic sr(input logic [7:0] x, input logic ack);
		q.push_back({1'b1, x});
		m.rbyte(ack);
	endtask
	task automatic seta(input logic [7:0] hi, input logic [7:0] lo);
		m.cond(1'b0);
		sw({TC, straps, 1'b0}, 1'b1);
		sw(hi, 1'b1);
		sw(lo, 1'b1);
	endtask
	task automatic rdw();
		m.cond(1'b0);
		sw({TC, straps, 1'b1}, 1'b1);
	endtask
	always @(posedge rs) begin
		e = (q.size() > 0) ? q.pop_front() : 9'h1FF;
		chk_bit("kind", e[8], rk);
		if (rk)
			chk_byte("read data", e[7:0], rv);
		else
			chk_bit("ack", e[0], rv[0]);
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (write_refused === 1'b1)
			n_ref++;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		{srst, write_protect, straps} = {1'b1, 1'b0, 3'h0};
		repeat (4) @(negedge ref_clk);
		srst = 1'b0;
		repeat (4) @(negedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk) {write_protect, straps} = {1'($random(seed)), 3'(i)};
			m.cond(1'b0);
			sw({TC, ~straps, 1'b0}, 1'b0);
			m.cond(1'b0);
			sw({TC ^ 4'h8, straps, 1'b0}, 1'b0);
			m.cond(1'b0);
			sw({TC, straps, 1'b0}, 1'b1);
			m.cond(1'b1);
		end
		@(negedge ref_clk) write_protect = 1'b0;
		$display("address test done");
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		seta(8'h7F, 8'hFF);
		sw(d0, 1'b1);
		sw(d1, 1'b1);
		m.cond(1'b1);
		seta(8'h7F, 8'hFF);
		rdw();
		sr(d0, 1'b1);
		sr(d1, 1'b0);
		m.cond(1'b1);
		$display("wrap test done");
		@(negedge ref_clk) write_protect = 1'b1;
		seta(8'h7F, 8'hFF);
		sw(~d0, 1'b1);
		m.cond(1'b1);
		chk_bit("refused", 1'b1, 1'(n_ref == 1));
		seta(8'h7F, 8'hFF);
		rdw();
		sr(d0, 1'b0);
		m.cond(1'b1);
		@(negedge ref_clk) write_protect = 1'b0;
		$display("protect test done");
		m.cond(1'b0);
		sw({TC, straps, 1'b0}, 1'b1);
		m.wbyte(8'h00, 4);
		m.cond(1'b1);
		repeat (8) @(negedge ref_clk);
		chk_bit("addressed", 1'b0, addressed);
		rdw();
		sr(d1, 1'b0);
		m.cond(1'b1);
		$display("abort test done");
		test_done();
	end
endmodule
bind mem_slave mem_slave_properties chk (.ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(write_protect), .bus_select_straps(bus_select_straps),
	.addressed(addressed), .write_refused(write_refused));
